// *** rtl/otr_pkg.sv ***
/*
 * Constants for the output current copy trim register bank: register
 * addresses, field positions, reset values, serial frame layout and the
 * percent steps of the trim codes.
 * Assumes a single 100 MHz clock domain and a host that frames every
 * access with the select pin.
 */
package otr_pkg;

   // ==========================================================
   // Register map
   localparam int OTR_ADDR_W_DEF = 7;
   localparam int OTR_ADDR_MIN_W = 5;
   localparam logic [7:0] OTR_TRIM2_ADDR = 8'h10;
   localparam logic [7:0] OTR_TRIM3_ADDR = 8'h11;
   localparam logic [7:0] OTR_TRIM_RESET = 8'h00;
   localparam logic [7:0] OTR_READ_VALUE = 8'h00;

   // ==========================================================
   // Field layout
   localparam int OTR_B12_LSB = 0;
   localparam int OTR_B34_LSB = 6;
   localparam int OTR_HS23_LSB = 3;
   localparam int OTR_HS1_LSB = 0;
   localparam int OTR_DATA_W = 8;

   // ==========================================================
   // Trim steps in percent
   localparam logic signed [4:0] OTR_PCT_STEP = 5'sh05;
   localparam logic signed [4:0] OTR_PCT_ZERO = 5'sh00;
   localparam logic signed [4:0] OTR_PCT_M10 = -5'sh0A;
   localparam logic signed [4:0] OTR_PCT_P5 = 5'sh05;
   localparam logic signed [4:0] OTR_PCT_P10 = 5'sh0A;
   localparam logic [2:0] OTR_CODE_RSVD = 3'h4;

   // ==========================================================
   // Pin idle levels
   localparam logic OTR_SS_IDLE = 1'b1;
   localparam logic OTR_SCLK_IDLE = 1'b0;

   typedef enum logic [1:0] {st_idle, st_shift, st_done} otr_state_t;

endpackage : otr_pkg

// *** rtl/otr_trim_regs.sv ***
/*
 * Write-only current copy trim registers of the analog die, reached over
 * the internal serial port: the low three bits of the second trim
 * register and the whole third trim register, with decoded percent outputs.
 * Assumes serial mode 0, MSB first, a frame of one write flag, the address
 * and one data byte, and a serial clock far slower than mclk so that the
 * data pin is settled when its clock edge is seen.
 */
// Overview of operation
// - Bridge 1/2 high range trim is a 3-bit write-only field, reset to 0.
// - Codes 0..3 give 0/-5/-10/-15 %, 5..7 give +5/+10/+15 %, 4 is reserved.
// - Trim register three at 0x11 is write-only, reads 0 and resets to 0.
// - Its bits 7:6 are the bridge 3/4 low range trim, reset to 0.
// - That two-bit code means 0, -10, +5 and +10 percent for 00, 01, 10, 11.
// - Bits 5:3 of it are the high-side two and three trim, reset to zero.
// - That code uses the same signed five percent mapping with 100 reserved.
// - Bits 2:0 of it are the high-side one trim, reset to zero.
// - That code uses the same signed five percent mapping with 100 reserved.
// - Bridge 1/2 high range trim is bits 2:0 of write-only 0x10, reads 0.
module otr_trim_regs
   import otr_pkg::*;
#(
   parameter int ADDR_W = OTR_ADDR_W_DEF
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic spi_ss_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic [2:0] bridge12_high_range_trim,
   output logic [1:0] bridge34_low_range_trim,
   output logic [2:0] highside23_trim,
   output logic [2:0] highside1_trim,
   output logic signed [4:0] bridge12_pct,
   output logic signed [4:0] bridge34_pct,
   output logic signed [4:0] highside23_pct,
   output logic signed [4:0] highside1_pct
);

   // ==========================================================
   // Parameters and checks
   localparam int FRAME_W = 1 + ADDR_W + OTR_DATA_W;
   localparam int CNT_W = $clog2(FRAME_W);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_W - 1);

   generate
      if (ADDR_W < OTR_ADDR_MIN_W)
      begin : g_bad_addr_w
         $error("ADDR_W too narrow for the trim register addresses");
      end
   endgenerate

   // ==========================================================
   // Trim code decoding
   // Reserved code 100 is undefined; it decodes to no change
   function automatic logic signed [4:0] pct3(input logic [2:0] code);
      logic signed [4:0] mag;
      mag = 5'(OTR_PCT_STEP * $signed({3'h0, code[1:0]}));
      if (code == OTR_CODE_RSVD)
         pct3 = OTR_PCT_ZERO;
      else if (code[2])
         pct3 = mag;
      else
         pct3 = -mag;
   endfunction : pct3

   function automatic logic signed [4:0] pct2(input logic [1:0] code);
      case (code)
         2'h0: pct2 = OTR_PCT_ZERO;
         2'h1: pct2 = OTR_PCT_M10;
         2'h2: pct2 = OTR_PCT_P5;
         default: pct2 = OTR_PCT_P10;
      endcase
   endfunction : pct2

   // ==========================================================
   // Reset release
   logic [1:0] rst_s_q;
   logic rst_n_q;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         rst_s_q <= 2'h0;
      else
         rst_s_q <= {rst_s_q[0], 1'b1};
   end
   assign rst_n_q = rst_s_q[1];

   // ==========================================================
   // Pin synchronisers and filters
   // Three stages; a level counts once stages two and three agree
   logic [2:0] ss_s_q, sclk_s_q, mosi_s_q;
   logic ss_f_q, sclk_f_q, mosi_f_q;
   wire ss_ok = ss_s_q[1] == ss_s_q[2];
   wire sclk_ok = sclk_s_q[1] == sclk_s_q[2];
   wire mosi_ok = mosi_s_q[1] == mosi_s_q[2];

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ss_s_q <= {3{OTR_SS_IDLE}};
         sclk_s_q <= {3{OTR_SCLK_IDLE}};
         mosi_s_q <= 3'h0;
         ss_f_q <= OTR_SS_IDLE;
         sclk_f_q <= OTR_SCLK_IDLE;
         mosi_f_q <= 1'b0;
      end
      else
      begin
         ss_s_q <= {ss_s_q[1:0], spi_ss_n};
         sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
         mosi_s_q <= {mosi_s_q[1:0], spi_mosi};
         ss_f_q <= ss_ok ? ss_s_q[2] : ss_f_q;
         sclk_f_q <= sclk_ok ? sclk_s_q[2] : sclk_f_q;
         mosi_f_q <= mosi_ok ? mosi_s_q[2] : mosi_f_q;
      end
   end

   wire ss_fall = ss_ok && !ss_s_q[2] && ss_f_q;
   wire ss_rise = ss_ok && ss_s_q[2] && !ss_f_q;
   wire sclk_rise = sclk_ok && sclk_s_q[2] && !sclk_f_q;

   // ==========================================================
   // Frame receiver
   otr_state_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [FRAME_W-2:0] shift_q;

   wire commit = (st_q == st_shift) && sclk_rise && (cnt_q == LAST_BIT);
   wire [FRAME_W-1:0] word = {shift_q, mosi_f_q};
   wire wr_flag = word[FRAME_W-1];
   wire [ADDR_W-1:0] addr = word[FRAME_W-2 -: ADDR_W];
   wire [7:0] data = word[OTR_DATA_W-1:0];
   wire hit2 = commit && wr_flag && addr == ADDR_W'(OTR_TRIM2_ADDR);
   wire hit3 = commit && wr_flag && addr == ADDR_W'(OTR_TRIM3_ADDR);

   // A frame cut short by the select pin is dropped whole
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         st_idle: if (ss_fall) st_d = st_shift;
         st_shift:
            if (ss_rise) st_d = st_idle;
            else if (commit) st_d = st_done;
         default: if (ss_rise) st_d = st_idle;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         st_q <= st_idle;
         cnt_q <= '0;
         shift_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         if (ss_fall)
            cnt_q <= '0;
         else if (st_q == st_shift && sclk_rise)
            cnt_q <= cnt_q + 1'b1;
         if (st_q == st_shift && sclk_rise)
            shift_q <= word[FRAME_W-2:0];
      end
   end

   // ==========================================================
   // Trim registers
   logic [2:0] trim2_q;
   logic [7:0] trim3_q;

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         trim2_q <= OTR_TRIM_RESET[2:0];
         trim3_q <= OTR_TRIM_RESET;
      end
      else
      begin
         if (hit2)
            trim2_q <= data[OTR_B12_LSB +: 3];
         if (hit3)
            trim3_q <= data;
      end
   end

   assign bridge12_high_range_trim = trim2_q;
   assign bridge34_low_range_trim = trim3_q[OTR_B34_LSB +: 2];
   assign highside23_trim = trim3_q[OTR_HS23_LSB +: 3];
   assign highside1_trim = trim3_q[OTR_HS1_LSB +: 3];

   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         bridge12_pct <= OTR_PCT_ZERO;
         bridge34_pct <= OTR_PCT_ZERO;
         highside23_pct <= OTR_PCT_ZERO;
         highside1_pct <= OTR_PCT_ZERO;
      end
      else
      begin
         bridge12_pct <= pct3(bridge12_high_range_trim);
         bridge34_pct <= pct2(bridge34_low_range_trim);
         highside23_pct <= pct3(highside23_trim);
         highside1_pct <= pct3(highside1_trim);
      end
   end

   // ==========================================================
   // Read path
   // Every register here is write-only, so a selected read shifts out zero
   assign spi_miso = OTR_READ_VALUE[OTR_DATA_W-1];
   assign spi_miso_oe = !ss_f_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n_q);

   a_trim3_bridge34: assert property (
      hit3 |=> bridge34_low_range_trim == $past(data[7:6]))
      else $error("bridge 3/4 trim did not take bits 7:6");
   a_trim3_hs23: assert property (
      hit3 |=> highside23_trim == $past(data[5:3]))
      else $error("high-side 2/3 trim did not take bits 5:3");
   a_trim3_hs1: assert property (
      hit3 |=> highside1_trim == $past(data[2:0]))
      else $error("high-side 1 trim did not take bits 2:0");
   a_trim2_bridge12: assert property (
      hit2 |=> bridge12_high_range_trim == $past(data[2:0]))
      else $error("bridge 1/2 trim did not take bits 2:0");
   a_other_addr_hold: assert property (
      !hit2 && !hit3 |=> $stable(trim2_q) && $stable(trim3_q))
      else $error("trim changed without a matching write");
   a_read_is_zero: assert property (
      $rose(spi_miso_oe) |->
         !$past(spi_ss_n, 3) && !$past(spi_ss_n, 4) && !spi_miso)
      else $error("read enable rose without a settled select or not zero");
   a_b12_pct_map: assert property (
      bridge12_high_range_trim == 3'h3 |=> bridge12_pct == -5'sh0F)
      else $error("bridge 1/2 code 011 not -15 percent");
   a_b34_pct_map: assert property (
      bridge34_low_range_trim == 2'h1 |=> bridge34_pct == -5'sh0A)
      else $error("bridge 3/4 code 01 not -10 percent");
   a_hs23_pct_map: assert property (
      highside23_trim == 3'h7 |=> highside23_pct == 5'sh0F)
      else $error("high-side 2/3 code 111 not +15 percent");
   a_hs1_pct_map: assert property (
      hit3 && data[2:0] == 3'h1 |-> ##2 highside1_pct == -5'sh05)
      else $error("high-side 1 code 001 not -5 percent");
   a_reset_clear: assert property (
      $rose(rst_n_q) |-> trim3_q == OTR_TRIM_RESET && trim2_q == 3'h0)
      else $error("trims not cleared by reset");

   c_write_trim3: cover property (hit3);
   c_write_trim2: cover property (hit2);
   c_cut_frame: cover property (st_q == st_shift && ss_rise);
   c_read_frame: cover property (commit && !wr_flag);

endmodule : otr_trim_regs

// *** test/otr_host_model.sv ***
/*
 * Host side model of the internal serial port: frames writes and reads,
 * can cut a frame short, and reloads the factory trim bytes on request.
 * Assumes the trim bank of otr_pkg behind the pins and a 100 MHz mclk.
 */
module otr_host_model
   import otr_pkg::*;
#(
   // Factory bytes of flash 0xFDC5 and 0xFDC6, values arbitrary
   parameter logic [7:0] FACT_TRIM2 = 8'h05,
   parameter logic [7:0] FACT_TRIM3 = 8'h9A
)
(
   input wire logic mclk,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   output logic spi_ss_n,
   output logic spi_sclk,
   output logic spi_mosi
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Pin state
   logic miso_hi;
   initial
   begin
      spi_ss_n = OTR_SS_IDLE;
      spi_sclk = OTR_SCLK_IDLE;
      spi_mosi = 1'b0;
      miso_hi = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
   endtask : wait_clk

   // ==========================================================
   // One frame; six mclk per level keeps the pin filter happy
   task automatic frame(input logic wr, input logic [7:0] addr,
                        input logic [7:0] data, input int nbits);
      logic [15:0] word;
      word = {wr, addr[6:0], data};
      @(posedge mclk);
      spi_ss_n <= 1'b0;
      for (int i = 15; i > 15 - nbits; i--)
      begin
         wait_clk(6);
         spi_mosi <= word[i];
         wait_clk(6);
         spi_sclk <= 1'b1;
         wait_clk(6);
         if (spi_miso_oe !== 1'b1 || spi_miso !== 1'b0)
            miso_hi = 1'b1;
         spi_sclk <= OTR_SCLK_IDLE;
      end
      wait_clk(12);
      spi_ss_n <= OTR_SS_IDLE;
      // Released data line must not look like held data
      spi_mosi <= ~spi_mosi;
      wait_clk(8);
   endtask : frame

   // ==========================================================
   // Reload after reset; the first flash byte belongs elsewhere
   task automatic reload();
      frame(1'b1, OTR_TRIM2_ADDR, FACT_TRIM2, 16);
      frame(1'b1, OTR_TRIM3_ADDR, FACT_TRIM3, 16);
   endtask : reload
endmodule : otr_host_model

// *** test/tb_top.sv ***
/*
 * Self-checking bench of the trim register bank: table of writes, then
 * read, foreign address, aborted frame and mid-run reset cases.
 * Assumes otr_host_model drives the serial pins.
 */
module tb_top
   import otr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Clock, reset and wiring
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   wire logic ss_n, sclk, mosi, miso, miso_oe;
   logic [2:0] b12, hs23, hs1;
   logic [1:0] b34;
   logic signed [4:0] p12, p34, p23, p1;
   int err_total = 0;
   int checked = 0;
   always #5 mclk = ~mclk;

   otr_trim_regs uut (.mclk(mclk), .reset_n(reset_n), .spi_ss_n(ss_n),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
      .spi_miso_oe(miso_oe), .bridge12_high_range_trim(b12),
      .bridge34_low_range_trim(b34), .highside23_trim(hs23),
      .highside1_trim(hs1), .bridge12_pct(p12), .bridge34_pct(p34),
      .highside23_pct(p23), .highside1_pct(p1));
   otr_host_model host (.mclk(mclk), .spi_miso(miso),
      .spi_miso_oe(miso_oe), .spi_ss_n(ss_n), .spi_sclk(sclk),
      .spi_mosi(mosi));

   // ==========================================================
   // Expectations and compares
   function automatic logic signed [4:0] pct3(input logic [2:0] c);
      return c[2] ? 5'(5 * c[1:0]) : 5'(-5 * c[1:0]);
   endfunction : pct3

   function automatic logic signed [4:0] pct2(input logic [1:0] c);
      return c[1] ? 5'(5 * (c[0] + 1)) : 5'(-10 * c[0]);
   endfunction : pct2

   task automatic chk_u(input string nm, input logic [2:0] e,
                        input logic [2:0] g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk_u

   task automatic chk_p(input string nm, input logic signed [4:0] e,
                        input logic signed [4:0] g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s exp %0d got %0d", nm, e, g);
      end
   endtask : chk_p

   // Nibbles of x: bridge12, bridge34, highside23, highside1
   task automatic chk_all(input logic [15:0] x, input string t);
      chk_u("b12", x[14:12], b12);
      chk_u("b34", {1'b0, x[9:8]}, {1'b0, b34});
      chk_u("hs23", x[6:4], hs23);
      chk_u("hs1", x[2:0], hs1);
      chk_p("b12_pct", pct3(x[14:12]), p12);
      chk_p("b34_pct", pct2(x[9:8]), p34);
      chk_p("hs23_pct", pct3(x[6:4]), p23);
      chk_p("hs1_pct", pct3(x[2:0]), p1);
      $display("test %s done", t);
   endtask : chk_all

   task automatic summarize();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // ==========================================================
   // Rows: address, data, expected nibbles; code 100 never sent
   logic [31:0] rows [14] = '{32'h118D_0215, 32'h10FB_3215, 32'h114E_3116,
      32'h1007_7116, 32'h11D7_7327, 32'h1001_1327, 32'h1118_1030,
      32'h1006_6030, 32'h10F8_0030, 32'h1005_5030, 32'h1129_5051,
      32'h1172_5162, 32'h11BB_5273, 32'h11C0_5300};

   initial
   begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (6) @(posedge mclk);
      chk_all(16'h0000, "reset");
      chk_u("miso_oe", 3'h0, {2'h0, miso_oe});
      foreach (rows[i])
      begin
         host.frame(1'b1, rows[i][31:24], rows[i][23:16], 16);
         chk_all(rows[i][15:0], "row");
      end
      host.frame(1'b0, OTR_TRIM3_ADDR, 8'hFF, 16);
      chk_all(16'h5300, "read");
      chk_u("miso", 3'h0, {2'h0, host.miso_hi});
      host.frame(1'b1, 8'h12, 8'hFF, 16);
      host.frame(1'b1, 8'h0F, 8'hFF, 16);
      chk_all(16'h5300, "foreign_addr");
      host.frame(1'b1, OTR_TRIM3_ADDR, 8'hFF, 8);
      chk_all(16'h5300, "abort");
      reset_n <= 1'b0;
      repeat (3) @(posedge mclk);
      chk_all(16'h0000, "mid_reset");
      reset_n <= 1'b1;
      repeat (6) @(posedge mclk);
      host.reload();
      chk_all(16'h5232, "reload");
      summarize();
   end

   initial
   begin
      repeat (60000) @(posedge mclk);
      err_total++;
      summarize();
   end
endmodule : tb_top
